//--- dtp_defines.vh
// Purpose: Constants for the down timer with pulse, event and width modes
// Assumes: 32-bit AHB-Lite register slave, one word per register
// Notes:   Offsets are byte addresses
`ifndef DTP_DEFINES_VH
`define DTP_DEFINES_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define DTP_OFF_MODE   4'h0
`define DTP_OFF_PRE    4'h4
`define DTP_OFF_CNT    4'h8
`define DTP_OFF_IRQ    4'hC

// ---------------------------------------------------------------
// Mode register fields
// ---------------------------------------------------------------
`define DTP_MODE_LO    0
`define DTP_MODE_HI    1
`define DTP_EDGE_BIT   2
`define DTP_RUN_BIT    3
`define DTP_SRC_LO     4
`define DTP_SRC_HI     5
`define DTP_CMP_EN_BIT 6
`define DTP_MODE_W     7

// ---------------------------------------------------------------
// Mode codes
// ---------------------------------------------------------------
`define DTP_M_TIMER    2'h0
`define DTP_M_PULSE    2'h1
`define DTP_M_EVENT    2'h2
`define DTP_M_WIDTH    2'h3

// ---------------------------------------------------------------
// Count source codes and divider figures
// ---------------------------------------------------------------
`define DTP_SRC_DIV1   2'h0
`define DTP_SRC_DIV8   2'h1
`define DTP_SRC_DIV32  2'h2
`define DTP_SRC_SUB32  2'h3
`define DTP_DIV8_LAST  5'h07
`define DTP_DIV32_LAST 5'h1F

// ---------------------------------------------------------------
// Status bits, reset values and bus transfer codes
// ---------------------------------------------------------------
`define DTP_IRQ_UFL    0
`define DTP_IRQ_PIN    1
`define DTP_RST_MODE   7'h00
`define DTP_RST_BYTE   8'hFF
`define DTP_HTRANS_NS  2'h2
`define DTP_HSIZE_WORD 3'h2

`endif

//--- dtp_timer.v
// Purpose: 8-bit down timer with 8-bit pre-divider, pulse output,
//          event counting and pulse width measurement, AHB-Lite slave
// Assumes: Single clock clk_sys at 50 MHz, async active-high rst;
//          subclock tick arrives already synchronous as a pulse
// Notes:
//
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "dtp_defines.vh"

module dtp_timer #(
  parameter W = 8
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        subclk_tick,
  input  wire        event_pin_i,
  output reg         event_pin_o,
  output reg         event_pin_oe,
  input  wire        gp_out_level,
  output reg         complement_out_pin,
  output reg         ufl_irq_req,
  output reg         pin_irq_req
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  reg [`DTP_MODE_W-1:0] mode_q;
  reg [W-1:0]           pre_cnt_q;
  reg [W-1:0]           pre_rld_q;
  reg [W-1:0]           cnt_q;
  reg [W-1:0]           cnt_rld_q;
  reg [4:0]             div_q;
  reg                   pin_s1_q;
  reg                   pin_s2_q;
  reg                   pin_s3_q;
  reg                   wr_pend_q;
  reg [3:0]             wr_addr_q;
  reg                   cmp_q;

  wire [1:0] mode     = mode_q[`DTP_MODE_HI:`DTP_MODE_LO];
  wire [1:0] src      = mode_q[`DTP_SRC_HI:`DTP_SRC_LO];
  wire       edge_sel = mode_q[`DTP_EDGE_BIT];
  wire       run      = mode_q[`DTP_RUN_BIT];
  wire       cmp_en   = mode_q[`DTP_CMP_EN_BIT];

  // Bus is zero-wait: every access completes in its data phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ---------------------------------------------------------------
  // Divided clock enables
  // ---------------------------------------------------------------
  // One shared counter makes both the /8 and /32 ticks
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_q <= 5'h00;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end

  wire tick8  = ((div_q & `DTP_DIV8_LAST) == `DTP_DIV8_LAST);
  wire tick32 = (div_q == `DTP_DIV32_LAST);
  reg  int_tick;

  // Selected internal count source
  always @* begin
    case (src)
      `DTP_SRC_DIV1:  int_tick = 1'b1;
      `DTP_SRC_DIV8:  int_tick = tick8;
      `DTP_SRC_DIV32: int_tick = tick32;
      `DTP_SRC_SUB32: int_tick = subclk_tick;
      default:        int_tick = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Event pin input synchroniser and edge detect
  // ---------------------------------------------------------------
  // Third stage only feeds edge detection, so s1 is never decoded
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= event_pin_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  wire in_rise = pin_s2_q & ~pin_s3_q;
  wire in_fall = ~pin_s2_q & pin_s3_q;
  wire in_edge = edge_sel ? in_fall : in_rise;

  // ---------------------------------------------------------------
  // Count source selection per mode
  // ---------------------------------------------------------------
  // Width mode: edge bit 0 measures high level, 1 measures low
  wire lvl_ok = edge_sel ? ~pin_s2_q : pin_s2_q;
  reg  src_ev;

  always @* begin
    case (mode)
      `DTP_M_EVENT: src_ev = in_edge;
      `DTP_M_WIDTH: src_ev = int_tick & lvl_ok;
      default:      src_ev = int_tick;
    endcase
  end

  wire step    = run & src_ev;
  wire pre_ufl = step & (pre_cnt_q == {W{1'b0}});
  wire ufl     = pre_ufl & (cnt_q == {W{1'b0}});

  // ---------------------------------------------------------------
  // AHB-Lite address phase capture
  // ---------------------------------------------------------------
  // Only the first 16 bytes are mapped; anything above reads 0
  wire in_map = (haddr[31:4] == 28'h0000000);
  wire acc    = hsel & hready & htrans[1];
  wire wr_acc = acc & hwrite & in_map;
  wire rd_acc = acc & ~hwrite;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 4'h0;
    end else begin
      wr_pend_q <= wr_acc;
      if (acc) begin
        wr_addr_q <= haddr[3:0];
      end
    end
  end

  wire wr_mode = wr_pend_q & (wr_addr_q == `DTP_OFF_MODE);
  wire wr_pre  = wr_pend_q & (wr_addr_q == `DTP_OFF_PRE);
  wire wr_cnt  = wr_pend_q & (wr_addr_q == `DTP_OFF_CNT);
  wire wr_irq  = wr_pend_q & (wr_addr_q == `DTP_OFF_IRQ);
  wire wr_mode_pulse = wr_mode &
    (hwdata[`DTP_MODE_HI:`DTP_MODE_LO] == `DTP_M_PULSE);

  // ---------------------------------------------------------------
  // Mode register
  // ---------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q <= `DTP_RST_MODE;
    end else if (wr_mode) begin
      mode_q <= hwdata[`DTP_MODE_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Pre-divider and main counter
  // ---------------------------------------------------------------
  // A bus write beats a count step in the same cycle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_cnt_q <= `DTP_RST_BYTE;
      pre_rld_q <= `DTP_RST_BYTE;
    end else if (wr_pre) begin
      pre_rld_q <= hwdata[W-1:0];
      pre_cnt_q <= hwdata[W-1:0];
    end else if (pre_ufl) begin
      pre_cnt_q <= pre_rld_q;
    end else if (step) begin
      pre_cnt_q <= pre_cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q     <= `DTP_RST_BYTE;
      cnt_rld_q <= `DTP_RST_BYTE;
    end else if (wr_cnt) begin
      cnt_rld_q <= hwdata[W-1:0];
      cnt_q     <= hwdata[W-1:0];
    end else if (ufl) begin
      cnt_q <= cnt_rld_q;
    end else if (pre_ufl) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end

  // ---------------------------------------------------------------
  // Pulse output and complement pin
  // ---------------------------------------------------------------
  // A pulse-mode write preloads the start level from the edge bit, so the
  // first pulse starts where software asked
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      event_pin_o  <= 1'b0;
      event_pin_oe <= 1'b0;
      cmp_q        <= 1'b1;
    end else begin
      event_pin_oe <= (mode == `DTP_M_PULSE);
      if (wr_mode_pulse) begin
        event_pin_o <= hwdata[`DTP_EDGE_BIT];
        cmp_q       <= ~hwdata[`DTP_EDGE_BIT];
      end else if (ufl && mode == `DTP_M_PULSE) begin
        event_pin_o <= ~event_pin_o;
        cmp_q       <= ~cmp_q;
      end
    end
  end

  // Next complement level, so the pin flips on the same edge as the
  // event pin instead of one cycle behind it
  wire cmp_d = wr_mode_pulse ? ~hwdata[`DTP_EDGE_BIT] :
               (ufl && mode == `DTP_M_PULSE) ? ~cmp_q : cmp_q;

  // Complement pin: timer waveform only in pulse mode when enabled
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      complement_out_pin <= 1'b0;
    end else if (mode == `DTP_M_PULSE && cmp_en) begin
      complement_out_pin <= cmp_d;
    end else begin
      complement_out_pin <= gp_out_level;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt request bits
  // ---------------------------------------------------------------
  // Output edge in pulse mode, input edge in event and width modes, none in timer mode
  wire out_rise = (mode == `DTP_M_PULSE) & ufl & ~event_pin_o;
  wire out_fall = (mode == `DTP_M_PULSE) & ufl & event_pin_o;
  wire out_edge = edge_sel ? out_fall : out_rise;
  wire pin_ev   = (mode == `DTP_M_PULSE) ? out_edge :
                  ((mode != `DTP_M_TIMER) & in_edge);
  wire clr_ufl  = wr_irq & ~hwdata[`DTP_IRQ_UFL];
  wire clr_pin  = wr_irq & ~hwdata[`DTP_IRQ_PIN];

  // Writing 0 clears a bit; a same-cycle event wins over the clear
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ufl_irq_req <= 1'b0;
      pin_irq_req <= 1'b0;
    end else begin
      if (ufl) begin
        ufl_irq_req <= 1'b1;
      end else if (clr_ufl) begin
        ufl_irq_req <= 1'b0;
      end
      if (pin_ev || wr_mode_pulse) begin
        pin_irq_req <= 1'b1;
      end else if (clr_pin) begin
        pin_irq_req <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (rd_acc && !in_map) begin
      hrdata <= 32'h00000000;
    end else if (rd_acc) begin
      case (haddr[3:0])
        `DTP_OFF_MODE: hrdata <= {25'h0000000, mode_q};
        `DTP_OFF_PRE:  hrdata <= {24'h000000, pre_cnt_q};
        `DTP_OFF_CNT:  hrdata <= {24'h000000, cnt_q};
        `DTP_OFF_IRQ:  hrdata <= {30'h00000000, pin_irq_req, ufl_irq_req};
        default:       hrdata <= 32'h00000000;
      endcase
    end
  end

endmodule // dtp_timer
`default_nettype wire

//--- dtp_timer_properties.sv
// Purpose: Port-level checks for the down timer
// Assumes: One clock, async active-high rst, zero-wait bus
// Notes:   Mode register is shadowed from bus writes
`timescale 1ns/100ps
`default_nettype none
module dtp_timer_properties (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        gp_out_level,
  input wire logic        event_pin_o,
  input wire logic        event_pin_oe,
  input wire logic        complement_out_pin,
  input wire logic        ufl_irq_req,
  input wire logic        pin_irq_req
);
  // ------------------------------
  // Write tracking
  // ------------------------------
  logic        wr_q;
  logic [31:0] ad_q;
  logic [6:0]  sh_q;
  wire         mw = wr_q && ad_q == 32'h0;
  wire         iw = wr_q && ad_q == 32'hC;
  // Shadow lands on the same edge as the real mode write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_q <= 1'b0;
      ad_q <= 32'h0;
      sh_q <= 7'h00;
    end else begin
      wr_q <= hsel & hready & htrans[1] & hwrite;
      ad_q <= haddr;
      if (mw)
        sh_q <= hwdata[6:0];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  a_oe_mode: assert property (event_pin_oe == ($past(sh_q[1:0]) == 2'h1))
    else $error("pin enable does not follow mode");
  a_cmp_port: assert property ($past(sh_q[1]) |->
    complement_out_pin == $past(gp_out_level))
    else $error("complement pin not general port");
  a_ufl_sticky: assert property (ufl_irq_req && !iw |=> ufl_irq_req)
    else $error("underflow request lost");
  a_pin_sticky: assert property (pin_irq_req && !iw |=> pin_irq_req)
    else $error("pin request lost");
  a_toggle_ufl: assert property (event_pin_oe && $past(event_pin_oe) &&
    !$past(mw) && $changed(event_pin_o) |-> ufl_irq_req)
    else $error("pin toggled without underflow");
  a_run_halt: assert property (!$past(sh_q[3]) && !$past(sh_q[3], 2)
    |-> !$rose(ufl_irq_req))
    else $error("underflow while stopped");
  a_pulse_sets: assert property (mw && hwdata[1:0] == 2'h1 |=> pin_irq_req)
    else $error("pulse mode write left pin request low");
endmodule // dtp_timer_properties

bind dtp_timer dtp_timer_properties u_props (.*);
`default_nettype wire

//--- dtp_pin_src.sv
// Purpose: External pulse source on the event pin
// Assumes: Pin pulled low when nobody drives it
// Notes:   Each pulse is 3 cycles high then 3 low
`timescale 1ns/100ps
`default_nettype none
module dtp_pin_src (
  input  wire logic       clk_sys,
  input  wire logic       go,
  input  wire logic [7:0] npulse,
  input  wire logic       pin_o,
  input  wire logic       pin_oe,
  output wire logic       pin,
  output wire logic       busy
);
  // ------------------------------
  // Pulse train
  // ------------------------------
  int   left = 0;
  int   ph = 0;
  logic lvl = 1'b0;
  // Fixed width keeps edges well apart for the input synchroniser
  always @(posedge clk_sys) begin
    if (go) begin
      left <= npulse;
      ph <= 0;
    end else if (left > 0) begin
      ph <= (ph == 5) ? 0 : ph + 1;
      lvl <= ph < 3;
      if (ph == 5)
        left <= left - 1;
    end
  end
  // Device output wins while it drives the pin
  assign pin  = pin_oe ? pin_o : lvl;
  assign busy = left > 0;
endmodule // dtp_pin_src
`default_nettype wire

//--- dtp_timer_tb_top.sv
// Purpose: Self-checking bench for the down timer
// Assumes: Zero-wait slave, event pin fed by dtp_pin_src
// Notes:   Periods predicted from divider, pre-divider, counter
`timescale 1ns/100ps
`default_nettype none
module dtp_timer_tb_top;
  logic        clk_sys, rst, hsel, hwrite, tick, gp, go;
  logic [31:0] haddr, hwdata, r, r2;
  logic [1:0]  htrans;
  logic [7:0]  np;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, pin, busy, ev_o, ev_oe, cmp, ufl, pirq;
  int          fail_count = 0, n_checks = 0, cyc = 0, n, m, c;
  int          divs[4] = '{1, 8, 32, 3};
  dtp_timer DUT (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .subclk_tick(tick), .event_pin_i(pin),
    .event_pin_o(ev_o), .event_pin_oe(ev_oe), .gp_out_level(gp),
    .complement_out_pin(cmp), .ufl_irq_req(ufl), .pin_irq_req(pirq));
  dtp_pin_src u_src (.clk_sys(clk_sys), .go(go), .npulse(np),
    .pin_o(ev_o), .pin_oe(ev_oe), .pin(pin), .busy(busy));
  // ------------------------------
  // Clock, ticks, timeout
  // ------------------------------
  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Slow source ticks every third cycle; port level is random
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    tick <= (cyc % 3) == 0;
    gp <= $urandom;
    if (cyc > 40000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Single AHB transfer; hready is waited on, never assumed
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(r, e);
  endtask
  task automatic gap;
    logic v;
    v = ev_o;
    c = 0;
    while (ev_o === v && c < 2000) begin
      @(negedge clk_sys);
      c++;
    end
  endtask
  task automatic pulses(input int p);
    np <= p;
    go <= 1;
    @(posedge clk_sys);
    go <= 0;
    @(posedge clk_sys);
    while (busy !== 1'b0) @(posedge clk_sys);
    repeat (8) @(posedge clk_sys);
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, go, np} = '0;
    rst = 1;
    n = $urandom(49655);
    repeat (4) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    rd(32'h4, 32'hFF);
    rd(32'h8, 32'hFF);
    rd(32'h10, 0);
    for (int s = 0; s < 4; s++) begin
      n = $urandom_range(2);
      m = $urandom_range(3);
      bus(1, 0, 1 | (s % 2) << 2 | s << 4 | 64);
      repeat (2) @(posedge clk_sys);
      chk(pirq, 1);
      chk(ev_o, s % 2);
      chk(cmp, !(s % 2));
      bus(1, 4, n);
      bus(1, 8, m);
      rd(32'h8, m);
      bus(1, 0, 9 | (s % 2) << 2 | s << 4 | 64);
      bus(1, 32'hC, 0);
      gap();
      gap();
      chk(c, divs[s] * (n + 1) * (m + 1));
      chk(cmp, !ev_o);
      chk(ufl, 1);
      chk(pirq, 1);
      bus(1, 0, 1 | s << 4);
      bus(0, 8, 0);
      r2 = r;
      repeat (50) @(posedge clk_sys);
      rd(32'h8, r2);
    end
    // Counting of external edges, both polarities
    for (int e = 0; e < 2; e++) begin
      bus(1, 0, 2 | e << 2);
      bus(1, 4, 1);
      bus(1, 8, 1);
      bus(1, 32'hC, 0);
      bus(1, 0, 10 | e << 2);
      pulses(3);
      chk(ufl, 0);
      chk(pirq, 1);
      pulses(1);
      chk(ufl, 1);
      rd(32'h8, 1);
    end
    // High-level width with no pre-division
    bus(1, 0, 3);
    bus(1, 4, 0);
    bus(1, 8, 200);
    bus(1, 0, 11);
    pulses(5);
    rd(32'h8, 185);
    stop_test();
  end
endmodule // dtp_timer_tb_top
`default_nettype wire
